// ===== include/mouse_calendar_pkg.sv
// constants shared by the pointing-device and calendar board glue logic
package mouse_calendar_pkg;

   // host i/o address width and decoded ports
   localparam int          ADDR_W          = 10;
   localparam logic [9:0]  PORT_DATA       = 10'h2fc;
   localparam logic [9:0]  PORT_CMD_STATUS = 10'h2fe;
   localparam logic [9:0]  PORT_RESET_SET  = 10'h2ff;
   localparam logic [9:0]  PORT_RESET_CLR  = 10'h2fd;

   // bit positions inside the address and the status byte
   localparam int          ADDR_BIT8_POS   = 8;
   localparam int          ADDR_CMD_POS    = 1;
   localparam int          STATUS_PF_POS   = 7;

   // microcontroller port bit positions for pointer and calendar lines
   localparam int          PTR_W           = 7;    // port 1 bits 0..6
   localparam int          P1_CAL_POS      = 7;    // port 1 bit 7
   localparam int          CAL_CTRL_W      = 4;    // port 2 bits 0..3
   localparam int          P2_PF_POS       = 7;    // port 2 bit 7

   // clock figures
   localparam longint      CLK_HZ          = 250_000_000;
   localparam longint      CAL_TB_HZ       = 32_768;
   localparam int          MCU_CLK_DIV     = 2;
   // half period of the calendar time base, rounded down
   localparam int          CAL_HALF_CYC    = int'(CLK_HZ / (2 * CAL_TB_HZ));

   // reset values
   localparam logic        RESET_LATCH_RST = 1'b0;

endpackage

// ===== logic/toggle_divider.sv
// divider that emits a one-cycle tick and toggles an output every tick
`timescale 1ns/1ps
module toggle_divider #(
   parameter int DIV = 2
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // divided outputs
   output logic      tick,
   output logic      level
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CW-1:0] count_q;

   // count up to the wrap; a divide by one ticks every cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= '0;
         tick    <= 1'b0;
      end else if (count_q == CW'(DIV - 1)) begin
         count_q <= '0;
         tick    <= 1'b1;
      end else begin
         count_q <= count_q + 1'b1;
         tick    <= 1'b0;
      end
   end

   // toggle stage: level changes once per tick, giving a half rate
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level <= 1'b0;
      end else if (count_q == CW'(DIV - 1)) begin
         level <= ~level;
      end
   end

endmodule // toggle_divider

// ===== logic/mouse_calendar_bus_glue.sv
// host bus glue for the pointing-device and calendar add-in board
`timescale 1ns/1ps

module mouse_calendar_bus_glue
   import mouse_calendar_pkg::*;
#(
   parameter int CAL_DIV = CAL_HALF_CYC
) (
   // clock (the bus oscillator) and power-on reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // host expansion bus, inputs asynchronous to clk, outputs registered on clk
   input  wire logic [ADDR_W-1:0] ioAddr,
   input  wire logic              ioReadN,
   input  wire logic              ioWriteN,
   input  wire logic              aen,
   input  wire logic              sysReset,
   input  wire logic [7:0]        hostDataIn,
   output logic      [7:0]        hostDataOut,
   output logic                   hostDataOe,
   output logic                   irq3,
   // microcontroller host-side bus
   output logic                   mcuSelN,
   output logic                   mcuReadN,
   output logic                   mcuWriteN,
   output logic                   mcuCmdSel,
   output logic      [7:0]        mcuDataOut,
   output logic                   mcuDataOe,
   input  wire logic [7:0]        mcuDataIn,
   input  wire logic              mcuIrq,
   output logic                   mcuClk,
   output logic                   mcuReset,
   // microcontroller peripheral ports
   output logic      [7:0]        mcuPort1In,
   output logic      [7:0]        mcuPort2In,
   input  wire logic [7:0]        mcuPort2Out,
   // pointing device pins
   input  wire logic [PTR_W-1:0]  pointerIn,
   // calendar chip pins
   input  wire logic              calendarData,
   input  wire logic              calendarPowerFailN,
   output logic [CAL_CTRL_W-1:0]  calendarCtrl,
   output logic                   calendarTimeBase,
   // status for the host side
   output logic                   calendarPowerFail
);

   // two-stage synchronisers for every pin that crosses into clk
   localparam int SW = ADDR_W + 4 + 8 + 8 + 1 + PTR_W + 2;
   // idle pin levels: strobes and the power-fail pin rest high, so no false edge follows reset
   localparam logic [SW-1:0] SYNC_IDLE = {{ADDR_W{1'b0}}, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0,
                                          {PTR_W{1'b0}}, 1'b0, 1'b1};

   logic [SW-1:0]       syncA_q;
   logic [SW-1:0]       syncB_q;
   logic [ADDR_W-1:0]   addrS;
   logic                readNS;
   logic                writeNS;
   logic                aenS;
   logic                sysResetS;
   logic [7:0]          hostDataS;
   logic [7:0]          mcuDataS;
   logic                mcuIrqS;
   logic [PTR_W-1:0]    pointerS;
   logic                calDataS;
   logic                calPfNS;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA_q <= SYNC_IDLE;
         syncB_q <= SYNC_IDLE;
      end else begin
         syncA_q <= {ioAddr, ioReadN, ioWriteN, aen, sysReset, hostDataIn,
                     mcuDataIn, mcuIrq, pointerIn, calendarData, calendarPowerFailN};
         syncB_q <= syncA_q;
      end
   end

   // unpack the synchronised pins
   assign {addrS, readNS, writeNS, aenS, sysResetS, hostDataS,
           mcuDataS, mcuIrqS, pointerS, calDataS, calPfNS} = syncB_q;

   // mcu port 2 lines come from another chip, so they cross two stages as well
   logic [CAL_CTRL_W-1:0] ctrlA_q;
   logic [CAL_CTRL_W-1:0] ctrlB_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrlA_q <= '0;
         ctrlB_q <= '0;
      end else begin
         ctrlA_q <= mcuPort2Out[CAL_CTRL_W-1:0];
         ctrlB_q <= ctrlA_q;
      end
   end

   // address match helper used for all four ports
   function automatic logic portHit(input logic [ADDR_W-1:0] a,
                                    input logic              bit8,
                                    input logic [ADDR_W-1:0] port);
      // bit 8 is taken from the buffered copy, never from the raw address
      portHit = (a[ADDR_W-1] == port[ADDR_W-1]) && (bit8 == port[ADDR_BIT8_POS])
                && (a[ADDR_BIT8_POS-1:0] == port[ADDR_BIT8_POS-1:0]);
   endfunction

   // buffered address bit 8 floats high once aen turns the buffer off
   logic bufferedAddressBit8;
   assign bufferedAddressBit8 = aenS ? 1'b1 : addrS[ADDR_BIT8_POS];

   // decoded strobes; aen also blocks directly so dma never selects
   logic anyCycle;
   logic hitCtrl;
   logic hitSet;
   logic hitClr;
   logic boardSel;
   assign anyCycle = (!readNS || !writeNS) && !aenS;
   assign hitCtrl  = portHit(addrS, bufferedAddressBit8, PORT_DATA)
                   || portHit(addrS, bufferedAddressBit8, PORT_CMD_STATUS);
   assign hitSet   = portHit(addrS, bufferedAddressBit8, PORT_RESET_SET);
   assign hitClr   = portHit(addrS, bufferedAddressBit8, PORT_RESET_CLR);
   assign boardSel = anyCycle && hitCtrl;

   // write edge: one pulse per host write, so a long strobe acts once
   logic writeNPrev_q;
   logic writePulse;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         writeNPrev_q <= 1'b1;
      end else begin
         writeNPrev_q <= writeNS;
      end
   end
   assign writePulse = writeNPrev_q && !writeNS && !aenS;

   // software reset latch; system reset clears it and wins over a set
   logic resetLatch_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         resetLatch_q <= RESET_LATCH_RST;
      end else if (sysResetS) begin
         resetLatch_q <= RESET_LATCH_RST;
      end else if (writePulse && hitSet) begin
         resetLatch_q <= 1'b1;
      end else if (writePulse && hitClr) begin
         resetLatch_q <= 1'b0;
      end
   end

   // microcontroller reset, held while in power-on reset too
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mcuReset <= 1'b1;
      end else begin
         mcuReset <= sysResetS || resetLatch_q;
      end
   end

   // select and strobes toward the microcontroller
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mcuSelN   <= 1'b1;
         mcuReadN  <= 1'b1;
         mcuWriteN <= 1'b1;
         mcuCmdSel <= 1'b0;
      end else begin
         mcuSelN   <= !boardSel;
         mcuReadN  <= !(boardSel && !readNS);
         mcuWriteN <= !(boardSel && !writeNS);
         mcuCmdSel <= addrS[ADDR_CMD_POS];
      end
   end

   // host data buffer: direction follows the cycle, enable follows select
   logic statusRead;
   assign statusRead = boardSel && !readNS
                     && portHit(addrS, bufferedAddressBit8, PORT_CMD_STATUS);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hostDataOut <= 8'h00;
         hostDataOe  <= 1'b0;
         mcuDataOut  <= 8'h00;
         mcuDataOe   <= 1'b0;
      end else begin
         hostDataOe  <= boardSel && !readNS;
         mcuDataOe   <= boardSel && !writeNS;
         mcuDataOut  <= hostDataS;
         hostDataOut <= mcuDataS;
         if (statusRead) begin
            // power-fail bit forced from the pin so it shows even under firmware reset
            hostDataOut[STATUS_PF_POS] <= !calPfNS;
         end
      end
   end

   // ready-for-transfer interrupt passes to the bus line, blocked while the microcontroller is held in reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq3 <= 1'b0;
      end else begin
         irq3 <= mcuIrqS && !mcuReset;
      end
   end

   // peripheral port images for pointer and calendar lines
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mcuPort1In        <= 8'hff;
         mcuPort2In        <= 8'hff;
         calendarCtrl      <= '0;
         calendarPowerFail <= 1'b0;
      end else begin
         mcuPort1In[PTR_W-1:0]    <= pointerS;
         mcuPort1In[P1_CAL_POS]   <= calDataS;
         mcuPort2In[P2_PF_POS]    <= calPfNS;
         mcuPort2In[P2_PF_POS-1:0] <= 7'h7f;
         calendarCtrl             <= ctrlB_q;
         calendarPowerFail        <= !calPfNS;
      end
   end

   // microcontroller clock: toggle every oscillator cycle
   logic mcuClkLevel;
   toggle_divider #(
      .DIV (MCU_CLK_DIV / 2)
   ) u_mcu_div (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (),
      .level (mcuClkLevel)
   );
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mcuClk <= 1'b0;
      end else begin
         mcuClk <= mcuClkLevel;
      end
   end

   // calendar time base runs free of the bus cycles, only from its own divider
   logic calLevel;
   toggle_divider #(
      .DIV (CAL_DIV)
   ) u_cal_div (
      .clk   (clk),
      .rstn  (rstn),
      .tick  (),
      .level (calLevel)
   );
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         calendarTimeBase <= 1'b0;
      end else begin
         calendarTimeBase <= calLevel;
      end
   end

endmodule // mouse_calendar_bus_glue

// ===== sim/mouse_calendar_bus_glue_checker.sv
// port assertions for the board glue
`timescale 1ns/1ps
module mouse_calendar_bus_glue_checker
   import mouse_calendar_pkg::*;
(
   // clock and reset
   input wire logic              clk,
   input wire logic              rstn,
   // host bus and mcu pins
   input wire logic [ADDR_W-1:0] ioAddr,
   input wire logic              ioReadN,
   input wire logic              ioWriteN,
   input wire logic              aen,
   input wire logic              sysReset,
   input wire logic              mcuIrq,
   // watched outputs
   input wire logic              irq3,
   input wire logic              mcuSelN,
   input wire logic              hostDataOe,
   input wire logic              mcuDataOe,
   input wire logic              mcuClk,
   input wire logic              mcuReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic boardHit, setWr, clrWr;
   // raw pin decode; the design sees it two sync stages and one register later
   assign boardHit = !aen && !(ioReadN && ioWriteN) && (ioAddr == PORT_DATA || ioAddr == PORT_CMD_STATUS);
   assign setWr    = !aen && !sysReset && ioAddr == PORT_RESET_SET;
   assign clrWr    = !aen && !sysReset && ioAddr == PORT_RESET_CLR;
   sequence irqHeld;
      (mcuIrq && !mcuReset)[*5];
   endsequence
   sel_decode_a: assert property (mcuSelN == !$past(boardHit, 3)) else $error("bad select");
   buf_gate_a: assert property ((hostDataOe || mcuDataOe) |-> !mcuSelN) else $error("buffer unselected");
   // the output stage lags the divider, so the first low phase after reset is one cycle longer
   clk_div_a: assert property ($past(rstn) && !mcuClk |=> mcuClk ##1 !mcuClk) else $error("mcu clock rate");
   latch_set_a: assert property ($fell(ioWriteN) && setWr |-> ##[3:5] mcuReset) else $error("set missed");
   latch_clr_a: assert property ($fell(ioWriteN) && clrWr |-> ##[3:5] !mcuReset) else $error("clear missed");
   sys_reset_a: assert property (sysReset[*4] |-> mcuReset) else $error("reset not passed");
   irq_relay_a: assert property (irqHeld |-> irq3) else $error("request lost");
   irq_gate_a: assert property (mcuReset[*2] |-> !irq3) else $error("request in reset");
endmodule // mouse_calendar_bus_glue_checker

bind mouse_calendar_bus_glue mouse_calendar_bus_glue_checker i_mouse_calendar_bus_glue_checker (.clk, .rstn,
   .aen, .sysReset, .ioReadN, .ioWriteN, .mcuIrq, .irq3, .mcuSelN, .hostDataOe, .mcuDataOe, .mcuClk, .mcuReset,
   .ioAddr);

// ===== sim/host_bus_model.sv
// host expansion bus master issuing single i/o cycles
`timescale 1ns/1ps
module host_bus_model
   import mouse_calendar_pkg::*;
(
   // pacing clock
   input  wire logic              clk,
   // host bus pins
   output logic      [ADDR_W-1:0] ioAddr,
   output logic                   ioReadN,
   output logic                   ioWriteN,
   output logic                   aen,
   output logic      [7:0]        hostDataIn
);
   // idle bus
   initial begin
      ioAddr     = 10'h000;
      ioReadN    = 1'b1;
      ioWriteN   = 1'b1;
      aen        = 1'b0;
      hostDataIn = 8'h00;
   end
   // address, aen and data lead the strobe by a cycle and stay with it
   task automatic busStart(input logic [ADDR_W-1:0] a, input logic wr, input logic dma, input logic [7:0] d);
      @(posedge clk);
      #1;
      ioAddr     = a;
      aen        = dma;
      hostDataIn = d;
      @(posedge clk);
      #1;
      ioReadN    = wr;
      ioWriteN   = !wr;
   endtask
   // strobe off first; a released bus no longer shows the old address
   task automatic busEnd();
      @(posedge clk);
      #1;
      ioReadN    = 1'b1;
      ioWriteN   = 1'b1;
      @(posedge clk);
      #1;
      ioAddr     = ~ioAddr;
      hostDataIn = ~hostDataIn;
      aen        = 1'b0;
   endtask
endmodule // host_bus_model

// ===== sim/tb_top.sv
// self-checking bench for the board glue
`timescale 1ns/1ps
module tb_top;
   import mouse_calendar_pkg::*;
   localparam int CAL_DIV_SIM = 4;
   logic                  clk, rstn, sysReset, mcuIrq, calendarData, calendarPowerFailN, aen, ioReadN, ioWriteN;
   logic                  hostDataOe, irq3, mcuSelN, mcuReadN, mcuWriteN, mcuCmdSel, mcuDataOe, mcuClk, mcuReset;
   logic                  calendarTimeBase, calendarPowerFail;
   logic [ADDR_W-1:0]     ioAddr;
   logic [7:0]            hostDataIn, hostDataOut, mcuDataOut, mcuDataIn, mcuPort1In, mcuPort2In, mcuPort2Out;
   logic [PTR_W-1:0]      pointerIn;
   logic [CAL_CTRL_W-1:0] calendarCtrl;
   int                    error_cnt = 0;
   int                    samples_checked = 0;

   mouse_calendar_bus_glue #(.CAL_DIV(CAL_DIV_SIM)) i_mouse_calendar_bus_glue (.clk, .rstn, .ioAddr, .ioReadN,
      .ioWriteN, .aen, .sysReset, .hostDataIn, .hostDataOut, .hostDataOe, .irq3, .mcuSelN, .mcuReadN, .mcuWriteN,
      .mcuCmdSel, .mcuDataOut, .mcuDataOe, .mcuDataIn, .mcuIrq, .mcuClk, .mcuReset, .mcuPort1In, .mcuPort2In,
      .mcuPort2Out, .pointerIn, .calendarData, .calendarPowerFailN, .calendarCtrl, .calendarTimeBase,
      .calendarPowerFail);
   host_bus_model i_host_bus_model (.clk, .ioAddr, .ioReadN, .ioWriteN, .aen, .hostDataIn);

   // 250 MHz oscillator
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // land just after an edge so inputs never race the sampling edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // strobe held while the caller looks; sync chain needs three edges
   task automatic io(input logic [ADDR_W-1:0] a, input logic wr, input logic dma, input logic [7:0] d);
      i_host_bus_model.busStart(a, wr, dma, d);
      settle(5);
   endtask
   task automatic done();
      i_host_bus_model.busEnd();
      settle(4);
   endtask
   // both ports, two near misses on bits 8 and 9, reads then writes
   task automatic t_decode();
      logic [ADDR_W-1:0] tab [6] = '{10'h2fc, 10'h2fe, 10'h2fd, 10'h0fc, 10'h3fc, 10'h2ff};
      logic              h;
      logic              w;
      for (int k = 0; k < 12; k++) begin
         h = (k % 6) < 2;
         w = k > 5;
         io(tab[k % 6], w, 1'b0, 8'ha5);
         chk({mcuSelN, mcuReadN, mcuWriteN, hostDataOe, mcuDataOe}, {!h, !(h && !w), !(h && w), h && !w, h && w});
         if (h) chk({mcuCmdSel, w ? mcuDataOut : hostDataOut}, {tab[k % 6][1], w ? 8'ha5 : 8'h5a});
         done();
      end
      $display("decode done");
   endtask
   // latch set and clear, dma lockout, system reset beating a set
   task automatic t_latch();
      io(PORT_RESET_CLR, 1'b1, 1'b0, 8'hff);
      chk(mcuReset, 1'b0);
      done();
      io(PORT_DATA, 1'b0, 1'b1, 8'h00);
      chk({mcuSelN, hostDataOe}, 2'b10);
      done();
      io(PORT_RESET_SET, 1'b1, 1'b0, 8'h00);
      chk(mcuReset, 1'b1);
      done();
      io(PORT_RESET_CLR, 1'b1, 1'b1, 8'h00);
      chk(mcuReset, 1'b1);
      done();
      sysReset = 1'b1;
      io(PORT_RESET_SET, 1'b1, 1'b0, 8'h3c);
      chk(mcuReset, 1'b1);
      done();
      sysReset = 1'b0;
      settle(5);
      chk(mcuReset, 1'b0);
      $display("latch done");
   endtask
   // mcu clock halves clk; time base toggles every CAL_DIV_SIM edges
   task automatic t_clocks();
      logic prev;
      int   n;
      for (int i = 0; i < 4; i++) begin
         prev = mcuClk;
         settle(1);
         chk(mcuClk, !prev);
      end
      for (int j = 0; j < 2; j++) begin
         prev = calendarTimeBase;
         n = 0;
         while (calendarTimeBase === prev && n < 20) begin
            settle(1);
            n++;
         end
         // a stuck time base uses up the bound and counts as a mismatch
         if (n >= 20) error_cnt++;
      end
      chk(16'(n), 16'(CAL_DIV_SIM));
      $display("clocks done");
   endtask
   // pin images, power fail in status, ready request and its gating
   task automatic t_ports();
      for (int i = 0; i < 2; i++) begin
         pointerIn = i ? 7'h2a : 7'h55;
         calendarData = !i;
         calendarPowerFailN = !i;
         mcuPort2Out = i ? 8'hf5 : 8'h0a;
         settle(5);
         chk(mcuPort1In, {!i[0], i ? 7'h2a : 7'h55});
         chk({mcuPort2In, 4'h0, calendarCtrl}, {!i[0], 7'h7f, 4'h0, i ? 4'h5 : 4'ha});
         chk(calendarPowerFail, i[0]);
      end
      mcuDataIn = 8'h00;
      io(PORT_CMD_STATUS, 1'b0, 1'b0, 8'h00);
      chk(hostDataOut, 8'h80);
      done();
      mcuIrq = 1'b1;
      settle(5);
      chk(irq3, 1'b1);
      io(PORT_RESET_SET, 1'b1, 1'b0, 8'h00);
      settle(2);
      chk(irq3, 1'b0);
      done();
      $display("ports done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      rstn = 1'b0;
      sysReset = 1'b0;
      mcuIrq = 1'b0;
      calendarData = 1'b0;
      calendarPowerFailN = 1'b1;
      mcuDataIn = 8'h5a;
      mcuPort2Out = 8'h00;
      pointerIn = 7'h00;
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      settle(2);
      t_decode();
      t_latch();
      t_clocks();
      t_ports();
      test_done();
   end
   // hang guard
   initial begin
      #100us;
      error_cnt++;
      test_done();
   end
endmodule // tb_top
